// ==== core/clk_src_pkg.sv ====
// shared constants, types and register map of the system clock source selector
package clk_src_pkg;

    // ----------------------------------------------------------------
    // register map (byte offsets)
    // ----------------------------------------------------------------
    localparam logic [7:0]  CLOCK_DIVISOR_REG_OFS  = 8'h00;
    localparam logic [7:0]  FAST_RC_TUNE_REG_OFS   = 8'h04;
    localparam logic [7:0]  CLOCK_STATUS_REG_OFS   = 8'h08;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int          POSTSCALE_LSB          = 8;
    localparam int          POSTSCALE_MSB          = 10;
    localparam logic [2:0]  POSTSCALE_RST          = 3'h0;
    localparam int          TUNE_WIDTH             = 6;
    localparam logic [5:0]  TUNE_RST               = 6'h00;
    localparam int          STATUS_MODE_LSB        = 0;
    localparam int          STATUS_PLL_BIT         = 4;
    localparam int          STATUS_OVERSPEED_BIT   = 5;

    // ----------------------------------------------------------------
    // initial oscillator select codes
    // ----------------------------------------------------------------
    localparam logic [2:0]  OSC_FAST_RC            = 3'h0;
    localparam logic [2:0]  OSC_FAST_RC_PLL        = 3'h1;
    localparam logic [2:0]  OSC_PRIMARY            = 3'h2;
    localparam logic [2:0]  OSC_PRIMARY_PLL        = 3'h3;
    localparam logic [2:0]  OSC_SECONDARY          = 3'h4;
    localparam logic [2:0]  OSC_SLOW_RC            = 3'h5;
    localparam logic [2:0]  OSC_FAST_RC_POSTSCALE  = 3'h6;
    localparam logic [2:0]  OSC_UNPROGRAMMED       = 3'h7;

    // primary oscillator mode codes
    localparam logic [1:0]  PRIM_EXTERNAL_CLOCK    = 2'h0;
    localparam logic [1:0]  PRIM_MEDIUM_SPEED      = 2'h1;
    localparam logic [1:0]  PRIM_HIGH_SPEED        = 2'h2;
    localparam logic [1:0]  PRIM_DISABLED          = 2'h3;

    // ----------------------------------------------------------------
    // nominal rates
    // ----------------------------------------------------------------
    localparam logic [31:0] FAST_RC_HZ             = 32'd7370000;
    localparam logic [31:0] SLOW_RC_HZ             = 32'd32768;
    localparam logic [31:0] SECONDARY_HZ           = 32'd32768;
    localparam logic [31:0] INSTR_MAX_HZ           = 32'd16000000;
    localparam int          PLL_SHIFT              = 2;
    localparam int          INSTR_DIV_SHIFT        = 1;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] initial_osc_select;
        logic [1:0] primary_osc_mode_select;
    } osc_cfg_s;

    typedef enum logic [3:0] {
        MODE_FAST_RC        = 4'h0,
        MODE_FAST_RC_PLL    = 4'h1,
        MODE_FAST_RC_DIV    = 4'h2,
        MODE_EXT_CLOCK      = 4'h3,
        MODE_MEDIUM_SPEED   = 4'h4,
        MODE_HIGH_SPEED     = 4'h5,
        MODE_EXT_CLOCK_PLL  = 4'h6,
        MODE_MEDIUM_PLL     = 4'h7,
        MODE_HIGH_PLL       = 4'h8,
        MODE_SECONDARY      = 4'h9,
        MODE_SLOW_RC        = 4'hA,
        MODE_FALLBACK_RC    = 4'hB
    } clk_mode_e;

endpackage

// ==== core/system_clock_source_select.sv ====
// system clock source selector with postscaler, instruction divider and register port
// ----------------------------------------------------------------
// What this block does
// R1: offers seven clock options: fast rc, fast rc with pll, primary, primary with pll, secondary, slow rc, fast rc postscaled.
// R2: the fast internal rc is taken as a 7.37 MHz source when selected.
// R3: software tunes the fast internal rc through a tuning register that drives the oscillator trim.
// R4: bits 10:8 of the clock divisor register pick the fast rc division from 1:2 to 1:256.
// R5: the primary oscillator works as medium speed crystal, high speed crystal or external clock.
// R6: in external clock mode the outside party drives its clock straight onto the primary input pin.
// R7: the secondary oscillator runs a 32.768 kHz crystal across its two pins.
// R8: the slow internal rc runs at 32.768 kHz and also clocks the watchdog and the clock failure monitor.
// R9: the 4x pll may only follow the fast rc or the primary oscillator.
// R10: at power-on reset the source comes from the 3-bit select and 2-bit primary mode configuration fields.
// R11: unprogrammed configuration bits give the fast rc as the power-on source.
// R12: the configuration fields encode twelve distinct clock modes.
// R13: the oscillator or pll output is divided by two to form the instruction and peripheral clocks.
// R14: instruction rates above 16 MHz are flagged as out of the supported range.
// R15: postscaler codes map to powers of two, code zero divides by two and code seven by 256.
// R16: the configuration selection is taken only during reset and held until the next reset.
// ----------------------------------------------------------------
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
module system_clock_source_select
    import clk_src_pkg::*;
#(
    parameter logic [31:0] PRIMARY_HZ = 32'd8000000
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // nonvolatile configuration
    input  wire osc_cfg_s    i_cfg,
    // oscillator ticks, one cycle each
    input  wire logic        i_fast_rc_tick,
    input  wire logic        i_pll_tick,
    input  wire logic        i_primary_tick,
    input  wire logic        i_secondary_tick,
    input  wire logic        i_slow_rc_tick,
    // register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    // oscillator control
    output logic      [5:0]  o_fast_rc_tune,
    output logic             o_pll_en,
    output logic             o_primary_en,
    output logic      [1:0]  o_primary_mode,
    output logic             o_secondary_en,
    output logic             o_overspeed,
    // derived clocks
    output logic             o_osc_tick,
    output logic             o_instr_tick,
    output logic             o_periph_tick,
    output logic             o_watchdog_ref_tick,
    output logic             o_failmon_ref_tick
);

    // ----------------------------------------------------------------
    // configuration capture and mode decode
    // ----------------------------------------------------------------
    osc_cfg_s  cfg_q;
    osc_cfg_s  cfg_d;
    clk_mode_e mode_q;
    clk_mode_e mode_d;

    always_comb begin
        cfg_d = i_rst_n ? cfg_q : i_cfg; // R10 R16
        case (cfg_d.initial_osc_select)
            OSC_FAST_RC:           mode_d = MODE_FAST_RC; // R2
            OSC_FAST_RC_PLL:       mode_d = MODE_FAST_RC_PLL; // R9
            OSC_FAST_RC_POSTSCALE: mode_d = MODE_FAST_RC_DIV;
            OSC_SECONDARY:         mode_d = MODE_SECONDARY; // R7
            OSC_SLOW_RC:           mode_d = MODE_SLOW_RC;
            OSC_UNPROGRAMMED:      mode_d = MODE_FAST_RC; // R11
            OSC_PRIMARY, OSC_PRIMARY_PLL: begin
                // R5 R12
                case (cfg_d.primary_osc_mode_select)
                    PRIM_EXTERNAL_CLOCK: mode_d = cfg_d.initial_osc_select[0] ?
                                                  MODE_EXT_CLOCK_PLL : MODE_EXT_CLOCK;
                    PRIM_MEDIUM_SPEED:   mode_d = cfg_d.initial_osc_select[0] ?
                                                  MODE_MEDIUM_PLL : MODE_MEDIUM_SPEED;
                    PRIM_HIGH_SPEED:     mode_d = cfg_d.initial_osc_select[0] ?
                                                  MODE_HIGH_PLL : MODE_HIGH_SPEED;
                    default:             mode_d = MODE_FALLBACK_RC;
                endcase
            end
            default:               mode_d = MODE_FAST_RC;
        endcase
    end

    always_ff @(posedge i_clk) begin
        cfg_q  <= cfg_d;
        mode_q <= mode_d;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [2:0]  postscale_q;
    logic [2:0]  postscale_d;
    logic [5:0]  tune_q;
    logic [5:0]  tune_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic        pll_q;
    logic        pll_d;
    logic        overspeed_q;
    logic        overspeed_d;
    logic [31:0] osc_hz;

    always_comb begin
        postscale_d = postscale_q;
        tune_d      = tune_q;
        rdata_d     = 16'h0000;
        if (i_wr && i_addr == CLOCK_DIVISOR_REG_OFS) begin
            postscale_d = i_wdata[POSTSCALE_MSB:POSTSCALE_LSB]; // R4
        end
        if (i_wr && i_addr == FAST_RC_TUNE_REG_OFS) begin
            tune_d = i_wdata[TUNE_WIDTH-1:0]; // R3
        end
        if (i_rd) begin
            case (i_addr)
                CLOCK_DIVISOR_REG_OFS: rdata_d[POSTSCALE_MSB:POSTSCALE_LSB] = postscale_q;
                FAST_RC_TUNE_REG_OFS:  rdata_d[TUNE_WIDTH-1:0] = tune_q;
                CLOCK_STATUS_REG_OFS: begin
                    rdata_d[STATUS_MODE_LSB+3:STATUS_MODE_LSB] = mode_q;
                    rdata_d[STATUS_PLL_BIT]       = pll_q;
                    rdata_d[STATUS_OVERSPEED_BIT] = overspeed_q;
                end
                default:               rdata_d = 16'h0000;
            endcase
        end
        if (!i_rst_n) begin
            postscale_d = POSTSCALE_RST;
            tune_d      = TUNE_RST;
        end
    end

    // nominal oscillator rate of the mode in force
    always_comb begin
        case (mode_q)
            MODE_FAST_RC_PLL:   osc_hz = FAST_RC_HZ << PLL_SHIFT; // R9
            MODE_FAST_RC_DIV:   osc_hz = FAST_RC_HZ >> (32'(postscale_q) + 32'd1);
            MODE_EXT_CLOCK,
            MODE_MEDIUM_SPEED,
            MODE_HIGH_SPEED:    osc_hz = PRIMARY_HZ;
            MODE_EXT_CLOCK_PLL,
            MODE_MEDIUM_PLL,
            MODE_HIGH_PLL:      osc_hz = PRIMARY_HZ << PLL_SHIFT;
            MODE_SECONDARY:     osc_hz = SECONDARY_HZ;
            MODE_SLOW_RC:       osc_hz = SLOW_RC_HZ; // R8
            default:            osc_hz = FAST_RC_HZ;
        endcase
        pll_d = (mode_q == MODE_FAST_RC_PLL) || (mode_q == MODE_EXT_CLOCK_PLL) ||
                (mode_q == MODE_MEDIUM_PLL) || (mode_q == MODE_HIGH_PLL); // R9
        overspeed_d = (osc_hz >> INSTR_DIV_SHIFT) > INSTR_MAX_HZ; // R14
    end

    always_ff @(posedge i_clk) begin
        postscale_q <= postscale_d;
        tune_q      <= tune_d;
        rdata_q     <= rdata_d;
        pll_q       <= pll_d;
        overspeed_q <= overspeed_d;
    end

    // ----------------------------------------------------------------
    // fast rc postscaler and source mux
    // ----------------------------------------------------------------
    logic [7:0] div_cnt_q;
    logic [7:0] div_cnt_d;
    logic [7:0] div_last;
    logic       div_tick_q;
    logic       div_tick_d;
    logic       osc_tick_q;
    logic       osc_tick_d;
    logic       phase_q;
    logic       phase_d;
    logic       instr_tick_q;
    logic       instr_tick_d;
    logic       wdt_tick_q;
    logic       wdt_tick_d;

    always_comb begin
        div_last   = 8'hFF >> (3'h7 - postscale_q); // R15
        div_cnt_d  = div_cnt_q;
        div_tick_d = 1'b0;
        if (i_fast_rc_tick) begin
            if (div_cnt_q >= div_last) begin
                div_cnt_d  = 8'h00;
                div_tick_d = 1'b1; // R4
            end else begin
                div_cnt_d = div_cnt_q + 8'h01;
            end
        end
        case (mode_q) // R1
            MODE_FAST_RC,
            MODE_FALLBACK_RC:   osc_tick_d = i_fast_rc_tick;
            MODE_FAST_RC_DIV:   osc_tick_d = div_tick_q;
            MODE_FAST_RC_PLL,
            MODE_EXT_CLOCK_PLL,
            MODE_MEDIUM_PLL,
            MODE_HIGH_PLL:      osc_tick_d = i_pll_tick;
            MODE_EXT_CLOCK,
            MODE_MEDIUM_SPEED,
            MODE_HIGH_SPEED:    osc_tick_d = i_primary_tick; // R6
            MODE_SECONDARY:     osc_tick_d = i_secondary_tick;
            MODE_SLOW_RC:       osc_tick_d = i_slow_rc_tick;
            default:            osc_tick_d = 1'b0;
        endcase
        phase_d      = osc_tick_q ? !phase_q : phase_q;
        instr_tick_d = osc_tick_q && phase_q; // R13
        wdt_tick_d   = i_slow_rc_tick; // R8
        if (!i_rst_n) begin
            div_cnt_d    = 8'h00;
            div_tick_d   = 1'b0;
            osc_tick_d   = 1'b0;
            phase_d      = 1'b0;
            instr_tick_d = 1'b0;
            wdt_tick_d   = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        div_cnt_q    <= div_cnt_d;
        div_tick_q   <= div_tick_d;
        osc_tick_q   <= osc_tick_d;
        phase_q      <= phase_d;
        instr_tick_q <= instr_tick_d;
        wdt_tick_q   <= wdt_tick_d;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    logic       osc_out_q;
    logic       primary_en_q;
    logic       secondary_en_q;

    always_ff @(posedge i_clk) begin
        osc_out_q      <= i_rst_n && osc_tick_q;
        primary_en_q   <= i_rst_n && (mode_q inside {MODE_EXT_CLOCK, MODE_MEDIUM_SPEED,
                          MODE_HIGH_SPEED, MODE_EXT_CLOCK_PLL, MODE_MEDIUM_PLL,
                          MODE_HIGH_PLL}); // R5
        secondary_en_q <= i_rst_n && (mode_q == MODE_SECONDARY); // R7
    end

    assign o_rdata             = rdata_q;
    assign o_fast_rc_tune      = tune_q;
    assign o_pll_en            = pll_q;
    assign o_primary_en        = primary_en_q;
    assign o_primary_mode      = cfg_q.primary_osc_mode_select;
    assign o_secondary_en      = secondary_en_q;
    assign o_overspeed         = overspeed_q;
    assign o_osc_tick          = osc_out_q;
    assign o_instr_tick        = instr_tick_q;
    assign o_periph_tick       = instr_tick_q;
    assign o_watchdog_ref_tick = wdt_tick_q;
    assign o_failmon_ref_tick  = wdt_tick_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_div_write;
        i_wr && i_addr == CLOCK_DIVISOR_REG_OFS;
    endsequence
    sequence s_div_read;
        i_rd && !i_wr && i_addr == CLOCK_DIVISOR_REG_OFS;
    endsequence

    property p_cfg_held;
        @(posedge i_clk) disable iff (!i_rst_n) ##1 $stable(cfg_q);
    endproperty
    a_cfg_held: assert property (p_cfg_held) else $error("config changed outside reset"); // R16

    property p_unprogrammed;
        @(posedge i_clk) disable iff (!i_rst_n)
            cfg_q.initial_osc_select == OSC_UNPROGRAMMED |-> mode_q == MODE_FAST_RC;
    endproperty
    a_unprogrammed: assert property (p_unprogrammed) else $error("unprogrammed not fast rc"); // R11

    property p_pll_sources;
        @(posedge i_clk) disable iff (!i_rst_n)
            o_pll_en |-> !(mode_q inside {MODE_SECONDARY, MODE_SLOW_RC, MODE_FAST_RC_DIV});
    endproperty
    a_pll_sources: assert property (p_pll_sources) else $error("pll on illegal source"); // R9

    property p_instr_half;
        @(posedge i_clk) disable iff (!i_rst_n)
            o_instr_tick |-> ##1 !o_instr_tick;
    endproperty
    a_instr_half: assert property (p_instr_half) else $error("instruction tick too dense"); // R13

    property p_instr_from_osc;
        @(posedge i_clk) disable iff (!i_rst_n)
            $rose(phase_q) && !osc_tick_q ##1 osc_tick_q |-> ##1 o_instr_tick;
    endproperty
    a_instr_from_osc: assert property (p_instr_from_osc) else $error("missed instr tick"); // R13

    property p_watchdog_ref;
        @(posedge i_clk) disable iff (!i_rst_n)
            $past(i_rst_n) |-> o_watchdog_ref_tick == $past(i_slow_rc_tick);
    endproperty
    a_watchdog_ref: assert property (p_watchdog_ref) else $error("watchdog ref wrong"); // R8

    property p_div_readback;
        @(posedge i_clk) disable iff (!i_rst_n)
            s_div_write ##1 s_div_read |-> ##1
                o_rdata[POSTSCALE_MSB:POSTSCALE_LSB] == $past(i_wdata[POSTSCALE_MSB:POSTSCALE_LSB], 2);
    endproperty
    a_div_readback: assert property (p_div_readback) else $error("divisor readback wrong"); // R4

    property p_div_by_two;
        @(posedge i_clk) disable iff (!i_rst_n)
            postscale_q == 3'h0 && div_cnt_q == 8'h01 && i_fast_rc_tick |-> ##1 div_tick_q;
    endproperty
    a_div_by_two: assert property (p_div_by_two) else $error("code zero not divide by two"); // R15

    property p_overspeed;
        @(posedge i_clk) disable iff (!i_rst_n)
            mode_q == MODE_FAST_RC_PLL && $stable(mode_q) |-> ##1 !o_overspeed;
    endproperty
    a_overspeed: assert property (p_overspeed) else $error("overspeed flagged in range"); // R14

endmodule // system_clock_source_select

// ==== bench/osc_source_model.sv ====
// behavioural external clock source that pulses the primary oscillator input
module osc_source_model #(
    parameter int PERIOD = 3
) (
    // clock and control
    input  wire logic i_clk,
    input  wire logic i_run,
    // oscillator pulse
    output logic      o_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial o_tick = 1'b0;
    // clock driven straight onto the input pin, no crystal, silent when idle
    always @(posedge i_clk) begin
        if (!i_run) begin
            cnt    <= 0;
            o_tick <= 1'b0;
        end else begin
            o_tick <= (cnt == PERIOD - 1);
            cnt    <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
        end
    end
endmodule // osc_source_model

// ==== bench/test_system_clock_source_select.sv ====
// self-checking bench of the system clock source selector
module test_system_clock_source_select
    import clk_src_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, run = 1'b0;
    logic i_fast_rc_tick = 1'b0, i_pll_tick = 1'b0, i_secondary_tick = 1'b0;
    logic i_slow_rc_tick = 1'b0, i_primary_tick;
    osc_cfg_s i_cfg = '0;
    logic [7:0] i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000, o_rdata, rd_q;
    logic [5:0] o_fast_rc_tune;
    logic [1:0] o_primary_mode;
    logic o_pll_en, o_primary_en, o_secondary_en, o_overspeed, o_osc_tick;
    logic o_instr_tick, o_periph_tick, o_watchdog_ref_tick, o_failmon_ref_tick;
    logic [31:0] rnd = 32'h0000925F;
    int n_mismatch = 0, checked = 0;
    int n_fast, n_pll, n_prim, n_sec, n_slow, n_osc, n_ins, n_per, n_wd, n_fm;
    int md, e_osc;
    initial forever #20 i_clk = ~i_clk;
    system_clock_source_select #(.PRIMARY_HZ(32'd10000000)) system_clock_source_select_i (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg(i_cfg),
        .i_fast_rc_tick(i_fast_rc_tick), .i_pll_tick(i_pll_tick),
        .i_primary_tick(i_primary_tick), .i_secondary_tick(i_secondary_tick),
        .i_slow_rc_tick(i_slow_rc_tick), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_fast_rc_tune(o_fast_rc_tune),
        .o_pll_en(o_pll_en), .o_primary_en(o_primary_en), .o_primary_mode(o_primary_mode),
        .o_secondary_en(o_secondary_en), .o_overspeed(o_overspeed), .o_osc_tick(o_osc_tick),
        .o_instr_tick(o_instr_tick), .o_periph_tick(o_periph_tick),
        .o_watchdog_ref_tick(o_watchdog_ref_tick), .o_failmon_ref_tick(o_failmon_ref_tick));
    osc_source_model #(.PERIOD(3)) osc_source_model_i (
        .i_clk(i_clk), .i_run(run), .o_tick(i_primary_tick));
    // ------------------------------------------------------------
    // pulse counters seen at the ports
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            {n_fast, n_pll, n_prim, n_sec, n_slow} = '0;
            {n_osc, n_ins, n_per, n_wd, n_fm} = '0;
        end else begin
            n_fast += i_fast_rc_tick; n_pll += i_pll_tick; n_prim += i_primary_tick;
            n_sec += i_secondary_tick; n_slow += i_slow_rc_tick; n_osc += o_osc_tick;
            n_ins += o_instr_tick; n_per += o_periph_tick;
            n_wd += o_watchdog_ref_tick; n_fm += o_failmon_ref_tick;
        end
    end
    // ------------------------------------------------------------
    // tasks and reference model
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h00400007 : 32'h00000000);
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic do_reset(input osc_cfg_s c);
        i_rst_n <= 1'b0;
        i_cfg   <= c;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1 rd_q = o_rdata;
        @(posedge i_clk);
    endtask
    // mode code from the two configuration fields
    function automatic int exp_mode(input logic [2:0] s, input logic [1:0] p);
        case (s)
            3'h1: return 1;
            3'h2: return (p == 2'h3) ? 11 : 3 + p;
            3'h3: return (p == 2'h3) ? 11 : 6 + p;
            3'h4: return 9;
            3'h5: return 10;
            3'h6: return 2;
            default: return 0;
        endcase
    endfunction
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(20000 * 40);
        n_mismatch++;
        summarize();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        // every configuration: decoded mode, enables and selected pulse path
        for (int c = 0; c < 32; c++) begin
            do_reset(osc_cfg_s'(c[4:0]));
            i_cfg <= osc_cfg_s'(~c[4:0]);
            md = exp_mode(c[4:2], c[1:0]);
            rd(CLOCK_STATUS_REG_OFS);
            chk("status", rd_q, 16'(md) | ((md inside {1, 6, 7, 8}) ? 16'h0010 : 16'h0000)
                | ((md inside {6, 7, 8}) ? 16'h0020 : 16'h0000));
            chk("pll_en", 16'(o_pll_en), 16'(md inside {1, 6, 7, 8}));
            chk("primary_en", 16'(o_primary_en), 16'(md inside {[3:8]}));
            chk("primary_mode", 16'(o_primary_mode), 16'(c[1:0]));
            chk("secondary_en", 16'(o_secondary_en), 16'(md == 9));
            chk("overspeed", 16'(o_overspeed), 16'(md inside {6, 7, 8}));
            run <= 1'b1;
            repeat (40) begin
                rnd = lfsr(rnd);
                {i_fast_rc_tick, i_pll_tick, i_secondary_tick, i_slow_rc_tick} <= rnd[3:0];
                @(posedge i_clk);
            end
            {i_fast_rc_tick, i_pll_tick, i_secondary_tick, i_slow_rc_tick} <= 4'h0;
            run <= 1'b0;
            repeat (6) @(posedge i_clk);
            case (md)
                1: e_osc = n_pll;
                2: e_osc = n_fast / 2;
                3, 4, 5: e_osc = n_prim;
                6, 7, 8: e_osc = n_pll;
                9: e_osc = n_sec;
                10: e_osc = n_slow;
                default: e_osc = n_fast;
            endcase
            chk("osc_ticks", 16'(n_osc), 16'(e_osc));
            chk("instr_ticks", 16'(n_ins), 16'(e_osc / 2));
            chk("periph_ticks", 16'(n_per), 16'(e_osc / 2));
            chk("watchdog_ticks", 16'(n_wd), 16'(n_slow));
            chk("failmon_ticks", 16'(n_fm), 16'(n_slow));
        end
        $display("test configuration modes done");
        // register port: masks, read-only status, unmapped place
        do_reset(osc_cfg_s'({OSC_FAST_RC, PRIM_DISABLED}));
        rd(CLOCK_DIVISOR_REG_OFS);
        chk("divisor_rst", rd_q, 16'(POSTSCALE_RST) << POSTSCALE_LSB);
        rd(FAST_RC_TUNE_REG_OFS);
        chk("tune_rst", rd_q, 16'(TUNE_RST));
        rnd = lfsr(rnd);
        wr(CLOCK_DIVISOR_REG_OFS, rnd[15:0]);
        rd(CLOCK_DIVISOR_REG_OFS);
        chk("divisor", rd_q, rnd[15:0] & 16'h0700);
        wr(FAST_RC_TUNE_REG_OFS, rnd[31:16]);
        rd(FAST_RC_TUNE_REG_OFS);
        chk("tune", rd_q, rnd[31:16] & 16'h003F);
        chk("tune_pin", 16'(o_fast_rc_tune), rnd[31:16] & 16'h003F);
        wr(CLOCK_STATUS_REG_OFS, 16'hFFFF);
        rd(CLOCK_STATUS_REG_OFS);
        chk("status_ro", rd_q, 16'h0000);
        wr(8'h0C, 16'hFFFF);
        rd(8'h0C);
        chk("unmapped", rd_q, 16'h0000);
        $display("test register port done");
        // every postscaler code divides by a power of two
        for (int n = 0; n < 8; n++) begin
            do_reset(osc_cfg_s'({OSC_FAST_RC_POSTSCALE, PRIM_DISABLED}));
            wr(CLOCK_DIVISOR_REG_OFS, 16'(n) << POSTSCALE_LSB);
            repeat (2 << (n + 1)) begin
                i_fast_rc_tick <= 1'b1;
                @(posedge i_clk);
                i_fast_rc_tick <= 1'b0;
                @(posedge i_clk);
            end
            repeat (6) @(posedge i_clk);
            chk("postscale_osc", 16'(n_osc), 16'h0002);
            chk("postscale_instr", 16'(n_ins), 16'h0001);
        end
        $display("test postscaler done");
        summarize();
    end
endmodule // test_system_clock_source_select
